// file: src/tmr2_params.svh
// Purpose: Constants for the capture/reload counter block
// Assumes: 32-bit AHB-Lite word registers
// Notes:   Offsets are byte addresses
`ifndef TMR2_PARAMS_SVH
`define TMR2_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define TMR2_OFS_CONTROL   8'h00
`define TMR2_OFS_COUNT     8'h04
`define TMR2_OFS_HOLDING   8'h08
`define TMR2_OFS_STATUS    8'h0C
`define TMR2_OFS_MASK      8'h10

// ****************************************
// Control field positions
// ****************************************
`define TMR2_BIT_OVF       7
`define TMR2_BIT_EXT       6
`define TMR2_BIT_RCLK      5
`define TMR2_BIT_TRANSMIT_CLOCK_SELECT      4
`define TMR2_BIT_EXEN      3
`define TMR2_BIT_RUN       2
`define TMR2_BIT_CSEL      1
`define TMR2_BIT_CPRL      0

// ****************************************
// Status bit positions and reset values
// ****************************************
`define TMR2_ST_OVF        0
`define TMR2_ST_EXT        1
`define TMR2_RST_CONTROL   8'h00
`define TMR2_RST_WORD16    16'h0000
`define TMR2_RST_FLAGS     2'h0

// ****************************************
// Timing
// ****************************************
`define TMR2_OSC_PER_TICK  12

`endif

// file: src/tmr2_pkg.sv
// Purpose: Types shared by the capture/reload counter block
// Assumes: tmr2_params.svh included alongside
// Notes:   Mode enum is Gray coded along off -> reload -> capture -> baud
package tmr2_pkg;

	// ****************************************
	// Operating modes
	// ****************************************
	typedef enum logic [1:0] {
		TMR2_OFF     = 2'h0,
		TMR2_RELOAD  = 2'h1,
		TMR2_CAPTURE = 2'h3,
		TMR2_BAUD    = 2'h2
	} tmr2_mode_t;

	// ****************************************
	// Control register layout
	// ****************************************
	typedef struct packed {
		logic overflow_flag;
		logic external_trigger_flag;
		logic receive_clock_select;
		logic transmit_clock_select;
		logic external_trigger_enable;
		logic run_bit;
		logic counter_select;
		logic capture_reload_select;
	} tmr2_ctrl_t;

	// ****************************************
	// Serial-clock outputs
	// ****************************************
	typedef struct packed {
		logic rx_use_tmr2;
		logic tx_use_tmr2;
		logic ovf_pulse;
	} tmr2_baud_t;

endpackage : tmr2_pkg

// file: src/tmr2_edge.sv
// Purpose: Two-stage synchroniser with falling edge detector
// Assumes: Input asynchronous or slow relative to hclk
// Notes:   First stage feeds only the second stage
module tmr2_edge (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic pin,
	output logic      fall
);

	logic meta;
	logic sync;
	logic prev;

	// ****************************************
	// Synchroniser and edge detect
	// ****************************************
	// Idle level high so reset produces no false edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta <= 1'b1;
			sync <= 1'b1;
			prev <= 1'b1;
			fall <= 1'b0;
		end else begin
			meta <= pin;
			sync <= meta;
			prev <= sync;
			fall <= prev & ~sync;
		end
	end

endmodule : tmr2_edge

// file: src/tmr2_top.sv
// Purpose: 16-bit timer/event counter with capture, auto-reload and baud modes
// Assumes: AHB-Lite single word transfers, hclk at 40 MHz
// Notes:   Zero wait states; flags cleared by writing one
//          Only haddr[7:0] is decoded, so upper address bits alias

`include "tmr2_params.svh"

module tmr2_top
	import tmr2_pkg::*;
#(
	parameter int unsigned CNT_W = 16,
	parameter int unsigned DIV   = `TMR2_OSC_PER_TICK
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        count_input,
	input  wire logic        external_trigger_input,
	output tmr2_pkg::tmr2_baud_t baud,
	output logic             irq
);
	import tmr2_pkg::*;

	// ****************************************
	// Elaboration checks
	// ****************************************
	// Count, holding and read paths are built for sixteen bits only
	if (CNT_W != 16) begin : g_bad_width
		$error("Counter width must be 16");
	end
	// Prescaler is eight bits wide and needs at least two states
	// A divider of one would make the timer tick on every clock
	if (DIV < 2 || DIV > 255) begin : g_bad_div
		$error("Prescale divider out of range");
	end

	// ****************************************
	// Declarations
	// ****************************************
	tmr2_ctrl_t    ctrl;
	logic [15:0]   count;
	logic [15:0]   holding;
	logic [1:0]    status;
	logic [1:0]    mask;
	logic [7:0]    presc;
	tmr2_mode_t    mode;
	logic          cnt_fall;
	logic          trig_fall;
	logic          tick;
	logic          wrap;
	logic          trig_act;
	logic          ap_valid;
	logic          ap_write;
	logic [7:0]    ap_addr;
	logic          wr_en;
	logic [1:0]    next_status;
	// One write strobe per register, decoded once from the data phase
	// Read strobe taken in the address phase for a registered answer
	logic          wr_ctrl;
	logic          wr_count;
	logic          wr_hold;
	logic          wr_stat;
	logic          wr_mask;
	logic          rd_take;

	// Address decode used for both read and write
	function automatic logic [2:0] reg_index(input logic [7:0] a);
		if (a == `TMR2_OFS_CONTROL) begin
			reg_index = 3'h1;
		end else if (a == `TMR2_OFS_COUNT) begin
			reg_index = 3'h2;
		end else if (a == `TMR2_OFS_HOLDING) begin
			reg_index = 3'h3;
		end else if (a == `TMR2_OFS_STATUS) begin
			reg_index = 3'h4;
		end else if (a == `TMR2_OFS_MASK) begin
			reg_index = 3'h5;
		end else begin
			reg_index = 3'h0;
		end
	endfunction : reg_index

	// ****************************************
	// Input edge detectors
	// ****************************************
	tmr2_edge u_cnt_edge (
		.hclk    (hclk),
		.hresetn (hresetn),
		.pin     (count_input),
		.fall    (cnt_fall)
	);

	tmr2_edge u_trig_edge (
		.hclk    (hclk),
		.hresetn (hresetn),
		.pin     (external_trigger_input),
		.fall    (trig_fall)
	);

	// ****************************************
	// Mode selection
	// ****************************************
	// Run bit dominates; serial-clock bits then override capture/reload
	// Mode is combinational so a control write acts on the next edge
	always_comb begin
		if (!ctrl.run_bit) begin
			mode = TMR2_OFF;
		end else if (ctrl.receive_clock_select || ctrl.transmit_clock_select) begin
			mode = TMR2_BAUD;
		end else if (ctrl.capture_reload_select) begin
			mode = TMR2_CAPTURE;
		end else begin
			mode = TMR2_RELOAD;
		end
	end

	// Tick source: prescaled clock or external edges
	// Event counting is limited to half of the clock rate
	assign tick = (mode != TMR2_OFF) &&
		(ctrl.counter_select ? cnt_fall : (presc == 8'(DIV - 1)));
	assign wrap = tick && (count == 16'hFFFF);
	// Baud mode locks out the trigger
	// Run off also drops trigger edges, so a stopped counter is frozen
	// Edges seen while disabled are lost, not queued
	assign trig_act = trig_fall && ctrl.external_trigger_enable &&
		(mode == TMR2_RELOAD || mode == TMR2_CAPTURE);

	// ****************************************
	// Prescaler
	// ****************************************
	// Free running so timer ticks keep a steady phase
	// Limitation: first tick after start lands anywhere within DIV clocks
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			presc <= 8'h00;
		end else if (presc == 8'(DIV - 1)) begin
			presc <= 8'h00;
		end else begin
			presc <= presc + 8'h01;
		end
	end

	// ****************************************
	// AHB-Lite address phase capture
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_valid <= 1'b0;
			ap_write <= 1'b0;
			ap_addr  <= 8'h00;
		end else if (hready) begin
			ap_valid <= hsel && htrans[1];
			ap_write <= hwrite;
			ap_addr  <= haddr[7:0];
		end
	end

	assign wr_en = ap_valid && ap_write;

	// ****************************************
	// Register strobes
	// ****************************************
	// Writes land at the edge that ends the data phase
	assign wr_ctrl  = wr_en && (reg_index(ap_addr) == 3'h1);
	assign wr_count = wr_en && (reg_index(ap_addr) == 3'h2);
	assign wr_hold  = wr_en && (reg_index(ap_addr) == 3'h3);
	assign wr_stat  = wr_en && (reg_index(ap_addr) == 3'h4);
	assign wr_mask  = wr_en && (reg_index(ap_addr) == 3'h5);

	// Read answer is registered, so it is latched at the address phase
	// Trade-off: zero wait states, but a read behind a write sees old data
	assign rd_take = hready && hsel && htrans[1] && !hwrite;

	// ****************************************
	// Control register
	// ****************************************
	// Flag fields mirror status, so only mode bits are stored here
	// Writes to the mirror bits are dropped; clear flags through status
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= tmr2_ctrl_t'(`TMR2_RST_CONTROL);
		end else begin
			if (wr_ctrl) begin
				ctrl <= tmr2_ctrl_t'(hwdata[7:0]);
			end
			ctrl.overflow_flag         <= 1'b0;
			ctrl.external_trigger_flag <= 1'b0;
		end
	end

	// ****************************************
	// Counter
	// ****************************************
	// Software write loses to hardware reload in the same cycle
	// Baud mode reloads on wrap too, which sets the serial bit period
	// A software write wins over a plain tick, so no count is doubled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count <= `TMR2_RST_WORD16;
		end else if (mode == TMR2_RELOAD && (wrap || trig_act)) begin
			count <= holding;
		end else if (mode == TMR2_BAUD && wrap) begin
			count <= holding;
		end else if (wr_count) begin
			count <= hwdata[15:0];
		end else if (tick) begin
			count <= count + 16'h0001;
		end
	end

	// ****************************************
	// Holding register
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			holding <= `TMR2_RST_WORD16;
		end else if (mode == TMR2_CAPTURE && trig_act) begin
			holding <= count;
		end else if (wr_hold) begin
			holding <= hwdata[15:0];
		end
	end

	// ****************************************
	// Status flags, write one to clear
	// ****************************************
	// Set beats clear so an event never slips past a clear
	// Software clear is applied first, then events in the same cycle
	always_comb begin
		next_status = status;
		if (wr_stat) begin
			next_status = status & ~hwdata[1:0];
		end
		if (wrap && mode != TMR2_BAUD) begin
			next_status[`TMR2_ST_OVF] = 1'b1;
		end
		if (trig_act) begin
			next_status[`TMR2_ST_EXT] = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status <= `TMR2_RST_FLAGS;
		end else begin
			status <= next_status;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask <= `TMR2_RST_FLAGS;
		end else if (wr_mask) begin
			mask <= hwdata[1:0];
		end
	end

	// ****************************************
	// Interrupt and serial clock outputs
	// ****************************************
	// Registered, yet updated on the same edge as the flags
	// Built from next_status to save one more cycle of latency
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_status & mask);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			baud <= '0;
		end else begin
			baud.rx_use_tmr2 <= ctrl.receive_clock_select;
			baud.tx_use_tmr2 <= ctrl.transmit_clock_select;
			baud.ovf_pulse   <= wrap && mode == TMR2_BAUD;
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	// Zero wait state; unmapped reads return zero
	// Value held until the next read is taken, so idle cycles keep it
	// Control read shows the status flags in its two top bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_take) begin
			case (reg_index(haddr[7:0]))
				3'h1: hrdata <= {24'h000000, status[`TMR2_ST_OVF],
					status[`TMR2_ST_EXT], ctrl[5:0]};
				3'h2: hrdata <= {16'h0000, count};
				3'h3: hrdata <= {16'h0000, holding};
				3'h4: hrdata <= {30'h0, status};
				3'h5: hrdata <= {30'h0, mask};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

endmodule : tmr2_top

// file: dv/tmr2_monitor.sv
// Purpose: Port-level checks for the counter block
// Assumes: Zero-wait AHB-Lite slave, byte offsets as in the params header
// Notes:   Control and mask are shadowed from bus writes
module tmr2_monitor
	import tmr2_pkg::*;
(
	input wire logic                 hclk,
	input wire logic                 hresetn,
	input wire logic                 hsel,
	input wire logic [31:0]          haddr,
	input wire logic [1:0]           htrans,
	input wire logic                 hwrite,
	input wire logic [31:0]          hwdata,
	input wire logic                 hready,
	input wire logic [31:0]          hrdata,
	input wire logic                 hreadyout,
	input wire logic                 hresp,
	input wire tmr2_pkg::tmr2_baud_t baud,
	input wire logic                 irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       dp;
	logic       dw;
	logic [7:0] da;
	logic [5:0] ctl;
	logic [1:0] msk;

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ****************************************
	// Bus shadows
	// ****************************************
	// Data phase follows every taken address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp <= 1'b0;
			dw <= 1'b0;
			da <= 8'h00;
		end else begin
			dp <= hsel && htrans[1] && hready;
			dw <= hwrite;
			da <= haddr[7:0];
		end
	end

	// Writable control bits and mask, flags excluded
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl <= 6'h00;
			msk <= 2'h0;
		end else if (dp && dw) begin
			if (da == 8'h00)
				ctl <= hwdata[5:0];
			if (da == 8'h10)
				msk <= hwdata[1:0];
		end
	end

	// ****************************************
	// Properties
	// ****************************************
	sequence ctl_rd_s;
		dp && !dw && da == 8'h00;
	endsequence

	resp_okay_a: assert property (hresp == 1'b0)
		else $error("response not OKAY");
	ready_high_a: assert property (hreadyout == 1'b1)
		else $error("wait state inserted");
	ctl_read_a: assert property (ctl_rd_s |-> hrdata[5:0] == ctl)
		else $error("control readback wrong");
	upper_zero_a: assert property (dp && !dw |-> hrdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	rx_route_a: assert property (baud.rx_use_tmr2 == $past(ctl[5]))
		else $error("receive clock routing wrong");
	tx_route_a: assert property (baud.tx_use_tmr2 == $past(ctl[4]))
		else $error("transmit clock routing wrong");
	ovf_baud_a: assert property (baud.ovf_pulse |->
		(ctl[2] && ctl[5:4] != 2'h0) || $past(ctl[2] && ctl[5:4] != 2'h0))
		else $error("baud pulse outside baud mode");
	irq_mask_a: assert property (msk == 2'h0 && $past(msk) == 2'h0 |-> !irq)
		else $error("interrupt with all masked");
	irq_cause_a: assert property (irq |-> msk != 2'h0 || $past(msk) != 2'h0)
		else $error("interrupt without enable");
endmodule : tmr2_monitor

// file: dv/tmr2_pins.sv
// Purpose: Driver standing in for the count and trigger sources
// Assumes: Pulse requests at least eight cycles apart
// Notes:   Lines idle high, each pulse low for LOW cycles
module tmr2_pins #(
	parameter int LOW = 3
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic fire_cnt,
	input  wire logic fire_trg,
	output logic      count_input,
	output logic      external_trigger_input
);
	timeunit 1ns;
	timeprecision 1ps;
	int cn;
	int tn;

	// ****************************************
	// Pulse shaping
	// ****************************************
	// Low time above two cycles so the synchroniser sees each level
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cn <= 0;
			tn <= 0;
		end else begin
			cn <= fire_cnt ? LOW : (cn > 0 ? cn - 1 : 0);
			tn <= fire_trg ? LOW : (tn > 0 ? tn - 1 : 0);
		end
	end
	assign count_input = (cn == 0);
	assign external_trigger_input = (tn == 0);
endmodule : tmr2_pins

// file: dv/tb_tmr2_top.sv
// Purpose: Self-checking bench for the counter block
// Assumes: hready fed back from hreadyout
// Notes:   Pin pulses come from the pin driver model
module tb_tmr2_top;
	timeunit 1ns;
	timeprecision 1ps;
	import tmr2_pkg::*;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        cnt_pin;
	logic        trg_pin;
	logic        fire_cnt;
	logic        fire_trg;
	tmr2_baud_t  baud;
	logic        irq;
	logic [31:0] q;
	int          mismatches;
	int          n_compared;
	int          cycles;
	int          pulses;

	tmr2_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .count_input(cnt_pin),
		.external_trigger_input(trg_pin), .baud(baud), .irq(irq));
	tmr2_pins pins (.hclk(hclk), .hresetn(hresetn), .fire_cnt(fire_cnt), .fire_trg(fire_trg),
		.count_input(cnt_pin), .external_trigger_input(trg_pin));

	// ****************************************
	// Clock, timeout and pulse tally
	// ****************************************
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (baud.ovf_pulse === 1'b1)
			pulses <= pulses + 1;
		if (cycles == 5000) begin
			mismatches = mismatches + 1;
			stop_test();
		end
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// One single transfer; no cycle count assumed, only hready
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk(q, e);
	endtask : rd
	task automatic fire(input logic t);
		fire_trg <= t;
		fire_cnt <= !t;
		@(posedge hclk);
		fire_trg <= 1'b0;
		fire_cnt <= 1'b0;
		repeat (12) @(posedge hclk);
	endtask : fire
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{hresetn, hsel, haddr, htrans, hwrite, hwdata, fire_cnt, fire_trg} = '0;
		hsize = 3'h2;
		{mismatches, n_compared, cycles, pulses} = '0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 6; i++)
			rd(8'(4 * i), 32'h0);
		bus(8'h14, 1'b1, 32'hFFFFFFFF);
		rd(8'h14, 32'h0);
		bus(8'h00, 1'b1, 32'h3B);
		rd(8'h00, 32'h3B);
		// Timer mode: about 122 running cycles
		bus(8'h04, 1'b1, 32'h0);
		bus(8'h00, 1'b1, 32'h04);
		repeat (120) @(posedge hclk);
		bus(8'h00, 1'b1, 32'h0);
		bus(8'h04, 1'b0, 32'h0);
		chk(32'(q >= 10 && q <= 11), 32'h1);
		// Auto-reload on rollover
		bus(8'h08, 1'b1, 32'hFFF0);
		bus(8'h04, 1'b1, 32'hFFF0);
		bus(8'h00, 1'b1, 32'h04);
		repeat (240) @(posedge hclk);
		bus(8'h00, 1'b1, 32'h0);
		bus(8'h04, 1'b0, 32'h0);
		chk(32'(q >= 32'hFFF0 && q < 32'hFFFF), 32'h1);
		rd(8'h0C, 32'h1);
		rd(8'h00, 32'h80);
		chk({31'h0, irq}, 32'h0);
		bus(8'h10, 1'b1, 32'h3);
		repeat (2) @(posedge hclk);
		chk({31'h0, irq}, 32'h1);
		bus(8'h0C, 1'b1, 32'h1);
		rd(8'h0C, 32'h0);
		chk({31'h0, irq}, 32'h0);
		// Event capture through rollover
		bus(8'h04, 1'b1, 32'hFFFE);
		bus(8'h00, 1'b1, 32'h0F);
		repeat (3) fire(1'b0);
		rd(8'h04, 32'h1);
		fire(1'b1);
		rd(8'h08, 32'h1);
		repeat (50) @(posedge hclk);
		rd(8'h0C, 32'h3);
		chk({31'h0, irq}, 32'h1);
		rd(8'h00, 32'hCF);
		bus(8'h0C, 1'b1, 32'h3);
		// Trigger with enable clear is ignored
		bus(8'h08, 1'b1, 32'h5555);
		bus(8'h00, 1'b1, 32'h07);
		fire(1'b1);
		rd(8'h08, 32'h5555);
		rd(8'h0C, 32'h0);
		// Trigger reload
		bus(8'h04, 1'b1, 32'h0100);
		bus(8'h00, 1'b1, 32'h0E);
		fire(1'b1);
		rd(8'h04, 32'h5555);
		rd(8'h0C, 32'h2);
		bus(8'h0C, 1'b1, 32'h3);
		// Baud mode: pulses, no flag, trigger ignored
		bus(8'h04, 1'b1, 32'hFFF0);
		bus(8'h08, 1'b1, 32'hFFF0);
		bus(8'h00, 1'b1, 32'h3C);
		fire(1'b1);
		repeat (400) @(posedge hclk);
		chk(32'(pulses > 0), 32'h1);
		chk({30'h0, baud.rx_use_tmr2, baud.tx_use_tmr2}, 32'h3);
		rd(8'h0C, 32'h0);
		rd(8'h08, 32'hFFF0);
		bus(8'h00, 1'b1, 32'h20);
		repeat (2) @(posedge hclk);
		chk({30'h0, baud.rx_use_tmr2, baud.tx_use_tmr2}, 32'h2);
		stop_test();
	end
endmodule : tb_tmr2_top

bind tmr2_top tmr2_monitor mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .baud(baud), .irq(irq));
